// >>> rtl/cmsm_pkg.sv
// Constants, types and register layout shared by the charger mode state machine.
// Assumes a single 125 MHz clock and comparator results already taken on that clock.
package cmsm_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ = 125_000_000;
  // Comparator inputs must hold steady this long before they count.
  localparam int DEB_TIME_NS = 1000;
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES = SEC_TIME_S * CLK_HZ;
  localparam logic [15:0] SEC_PER_HOUR = 16'h0E10;

  // Charge duration in hours, programmable over 1 to 10.
  localparam logic [3:0] CHG_HOURS_MIN = 4'h1;
  localparam logic [3:0] CHG_HOURS_MAX = 4'hA;
  localparam logic [3:0] CHG_HOURS_RST = 4'h4;
  // Pre-charge may last a quarter of the charge time: a right shift by two.
  localparam int PRE_LIMIT_SHIFT = 2;

  // Wishbone byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ELAPSED = 8'h08;
  localparam logic [7:0] REG_PRE_ELAPSED = 8'h0C;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_CHARGE = 3'b001,
    ST_SUSPEND = 3'b010,
    ST_PREFAULT = 3'b011,
    ST_MONITOR = 3'b100,
    ST_LDO = 3'b101
  } cmsm_state_e;

  // Debounced comparator results; a one means the named condition holds.
  typedef struct packed {
    logic input_undervoltage_lockout;
    logic input_overvoltage_fault;
    logic die_overtemperature;
    logic en_low;
    logic ntc_above_95;
    logic ntc_above_90;
    logic ntc_cold_trip;
    logic ntc_cold_clear;
    logic ntc_hot_trip;
    logic ntc_hot_clear;
    logic tsel_high;
    logic tsel_low;
    logic vbat_below_precharge;
    logic vbat_below_recharge;
    logic iout_above_term;
  } cmsm_cmp_s;

  localparam int CMP_W = $bits(cmsm_cmp_s);
  // Lockout and die overtemperature start asserted so nothing charges before the filters settle.
  localparam logic [14:0] CMP_RST = 15'h5000;

  typedef struct packed {
    logic [21:0] zero;
    logic pre_fault;
    logic temp_fault;
    logic battery_absent;
    logic led_oe;
    logic led_level;
    logic fast_current;
    logic output_on;
    cmsm_state_e state;
  } cmsm_status_s;

endpackage

// >>> rtl/cmsm_sync_deb.sv
// Two-flop synchroniser and stability filter, one lane per comparator bit.
// Assumes the comparators are quiet for longer than CNT cycles between real changes.
`timescale 1ns/1ps
module cmsm_sync_deb
  import cmsm_pkg::*;
#(
  parameter int W = CMP_W,
  parameter int CNT = DEB_CYCLES,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] filt_o
);

  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] CNT_TOP = CW'(CNT - 1);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_lane
      logic meta_q;
      logic sync_q;
      logic [CW-1:0] cnt_q;
      wire differs = sync_q != filt_o[g];
      always_ff @(posedge clk_i)
      begin
        meta_q <= raw_i[g];
        sync_q <= meta_q;
        if (rst_i)
        begin
          cnt_q <= '0;
          filt_o[g] <= RST_VAL[g];
        end
        else if (!differs)
          cnt_q <= '0;
        else if (cnt_q == CNT_TOP)
        begin
          cnt_q <= '0;
          filt_o[g] <= sync_q;
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
    end
  endgenerate

endmodule

// >>> rtl/cmsm_tick.sv
// One-second tick for the charge timers and the half-duty blink level.
// Assumes PERIOD is even so the blink halves are equal.
`timescale 1ns/1ps
module cmsm_tick
  import cmsm_pkg::*;
#(
  parameter int PERIOD = SEC_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic sec_tick_o,
  output logic blink_o
);

  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] HALF = CW'(PERIOD / 2 - 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_q;
  wire at_half = cnt_q == HALF;
  wire at_last = cnt_q == LAST;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      sec_tick_o <= 1'b0;
      blink_o <= 1'b0;
    end
    else
    begin
      cnt_q <= at_last ? '0 : cnt_q + 1'b1;
      sec_tick_o <= at_last;
      if (at_half || at_last)
        blink_o <= ~blink_o;
    end
  end

endmodule

// >>> rtl/cmsm_top.sv
// Mode state machine of a single-cell charger with a Wishbone register port.
// Assumes every comparator input is a level synchronous to clk_i.
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cmsm_top
  import cmsm_pkg::*;
#(
  parameter int SEC_CLK = SEC_CYCLES,
  parameter int DEB_CLK = DEB_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cmsm_cmp_s cmp_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic charger_output_o,
  output logic fast_current_program_o,
  output logic battery_absent_flag_o,
  output logic charge_status_led_o,
  output logic charge_status_led_oe_o
);

  // Filtered comparator levels; nothing past the filter reads the raw pins.
  cmsm_cmp_s c;
  logic [CMP_W-1:0] c_vec;
  logic sec_tick;
  logic blink;

  cmsm_sync_deb #(
    .W(CMP_W),
    .CNT(DEB_CLK),
    .RST_VAL(CMP_RST)
  ) u_deb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(cmp_i),
    .filt_o(c_vec)
  );

  assign c = cmsm_cmp_s'(c_vec);

  cmsm_tick #(
    .PERIOD(SEC_CLK)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sec_tick_o(sec_tick),
    .blink_o(blink)
  );

  // Both timers hold whole seconds; ten hours of seconds still fits in sixteen bits.
  cmsm_state_e state_q;
  cmsm_state_e state_d;
  logic [3:0] hours_q;
  logic [15:0] elapsed_q;
  logic [15:0] elapsed_d;
  logic [15:0] pre_q;
  logic [15:0] pre_d;
  logic temp_fault_q;
  logic temp_fault_d;
  logic led_latch_q;
  logic led_latch_d;
  logic ack_q;
  logic [31:0] rdata_q;

  // Mode of the timer-select pin.
  wire ldo_sel = c.tsel_high;
  wire no_timer = c.tsel_low && !c.tsel_high;
  wire use_timer = !c.tsel_low && !c.tsel_high;

  // Supply or enable missing forces the off state.
  wire disabled = c.input_undervoltage_lockout || c.en_low;

  // Window comparators trip outside 30%/75% and release only at the inner levels.
  wire temp_trip = c.ntc_cold_trip || c.ntc_hot_trip || c.ntc_above_95;
  wire temp_clear = c.ntc_cold_clear && c.ntc_hot_clear && !c.ntc_above_95;
  assign temp_fault_d = temp_trip || (temp_fault_q && !temp_clear);

  // Faults that stop current without ending the cycle.
  wire pulse_off = c.die_overtemperature || c.input_overvoltage_fault;

  // Charge time limit; the product stays below 16 bits for at most 10 hours.
  wire [15:0] limit = 16'(16'(hours_q) * SEC_PER_HOUR);
  wire [15:0] pre_limit = limit >> PRE_LIMIT_SHIFT;
  wire timer_done = use_timer && (elapsed_q >= limit);
  wire term_done = no_timer && !c.iout_above_term;
  wire pre_timeout = use_timer && c.vbat_below_precharge && (pre_q >= pre_limit);

  wire in_charge = state_q == ST_CHARGE;
  wire in_ldo = state_q == ST_LDO;
  wire in_suspend = state_q == ST_SUSPEND;
  wire in_prefault = state_q == ST_PREFAULT;

  // Output enable as seen this cycle.
  wire ldo_on = in_ldo && c.ntc_above_90 && !pulse_off;
  wire charge_on = in_charge && !pulse_off && !temp_fault_q;
  wire out_on = ldo_on || charge_on;

  // A cycle restarts from off, monitor or regulator; a resumed cycle keeps its time.
  wire fresh_src = (state_q == ST_OFF) || (state_q == ST_MONITOR) || in_ldo;
  wire new_cycle = (state_d == ST_CHARGE) && fresh_src;

  always_comb
  begin
    state_d = state_q;
    // Lockout or a grounded enable wins over every state, regulator mode included.
    if (disabled)
      state_d = ST_OFF;
    else
    begin
      unique case (state_q)
        ST_OFF:
        begin
          state_d = ldo_sel ? ST_LDO : ST_CHARGE;
        end
        ST_LDO:
        begin
          // Leaving regulator mode starts a fresh cycle with cleared timers.
          if (!ldo_sel)
            state_d = ST_CHARGE;
        end
        ST_CHARGE:
        begin
          if (ldo_sel)
            state_d = ST_LDO;
          else if (temp_fault_q)
            state_d = ST_SUSPEND;
          else if (pre_timeout)
            state_d = ST_PREFAULT;
          else if (timer_done || term_done)
            state_d = ST_MONITOR;
        end
        ST_SUSPEND:
        begin
          if (ldo_sel)
            state_d = ST_LDO;
          else if (!temp_fault_q)
            state_d = ST_CHARGE;
        end
        ST_PREFAULT:
        begin
          // The fault holds until the battery rises, the timer pin selects regulator mode or the device is disabled.
          if (ldo_sel)
            state_d = ST_LDO;
          else if (!c.vbat_below_precharge)
            state_d = ST_CHARGE;
        end
        ST_MONITOR:
        begin
          // Monitor keeps the output off and the latched complete level until a recharge.
          if (ldo_sel)
            state_d = ST_LDO;
          else if (c.vbat_below_recharge)
            state_d = ST_CHARGE;
        end
        default:
        begin
          state_d = ST_OFF;
        end
      endcase
    end
  end

  // The charge timer only advances on seconds in which current may flow.
  // Both counters saturate rather than wrap, so a long run can never fake a fresh start.
  always_comb
  begin
    elapsed_d = elapsed_q;
    if (new_cycle || state_d == ST_OFF)
      elapsed_d = '0;
    else if (sec_tick && charge_on && use_timer && elapsed_q != 16'hFFFF)
      elapsed_d = elapsed_q + 16'h0001;
  end

  // Pre-charge time restarts whenever the battery rises past the pre-charge level.
  always_comb
  begin
    pre_d = pre_q;
    if (new_cycle || state_d == ST_OFF || !c.vbat_below_precharge)
      pre_d = '0;
    else if (sec_tick && charge_on && use_timer && pre_q != 16'hFFFF)
      pre_d = pre_q + 16'h0001;
  end

  // End-of-charge latch; setting wins over the clear in the same cycle.
  wire led_set = out_on && !c.iout_above_term;
  wire led_clr = new_cycle || state_d == ST_OFF;
  assign led_latch_d = led_set || (led_latch_q && !led_clr);

  // A fault blink overrides the charging and complete levels, but never the lockout float.
  wire blink_fault = c.input_overvoltage_fault || c.die_overtemperature
    || in_suspend || in_prefault;
  wire led_high = led_latch_q || !c.iout_above_term;
  wire led_level = blink_fault ? blink : led_high;
  wire led_oe = !disabled;

  // Regulator mode always takes the fast limit; charge mode follows the battery level.
  wire fast_sel = in_ldo || !c.vbat_below_precharge;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_OFF;
      temp_fault_q <= 1'b0;
      led_latch_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      temp_fault_q <= temp_fault_d;
      led_latch_q <= led_latch_d;
    end
  end

  // Timer clears come from the next state, so a restart and its cleared count share one edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      elapsed_q <= '0;
      pre_q <= '0;
    end
    else
    begin
      elapsed_q <= elapsed_d;
      pre_q <= pre_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charger_output_o <= 1'b0;
      fast_current_program_o <= 1'b0;
      battery_absent_flag_o <= 1'b0;
      charge_status_led_o <= 1'b0;
      charge_status_led_oe_o <= 1'b0;
    end
    else
    begin
      charger_output_o <= out_on;
      fast_current_program_o <= fast_sel;
      battery_absent_flag_o <= c.ntc_above_95;
      charge_status_led_o <= led_level;
      charge_status_led_oe_o <= led_oe;
    end
  end

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads return zero.
  // The standing ack masks the request in its cycle, so a held strobe is taken every second cycle.
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire hit_ctrl = wb_adr_i == REG_CTRL;
  wire hit_status = wb_adr_i == REG_STATUS;
  wire hit_elapsed = wb_adr_i == REG_ELAPSED;
  wire hit_pre = wb_adr_i == REG_PRE_ELAPSED;
  // Only the low byte lane carries the hours field; a write without it changes nothing.
  wire wr_ctrl = req && wb_we_i && hit_ctrl && wb_sel_i[0];

  // Hours outside the legal span are pulled to the nearest limit.
  wire [3:0] hours_in = wb_dat_i[3:0];
  wire [3:0] hours_clamped = (hours_in < CHG_HOURS_MIN) ? CHG_HOURS_MIN
    : (hours_in > CHG_HOURS_MAX) ? CHG_HOURS_MAX : hours_in;

  // The five pin bits of the status mirror the registered pins, so software sees the levels the board sees.
  cmsm_status_s status;
  assign status.zero = '0;
  assign status.pre_fault = in_prefault;
  assign status.temp_fault = temp_fault_q;
  assign status.battery_absent = battery_absent_flag_o;
  assign status.led_oe = charge_status_led_oe_o;
  assign status.led_level = charge_status_led_o;
  assign status.fast_current = fast_current_program_o;
  assign status.output_on = charger_output_o;
  assign status.state = state_q;

  // Read data come from a register, so they stand unchanged through the ack cycle.
  wire [31:0] rmux = hit_ctrl ? {28'h0000000, hours_q}
    : hit_status ? 32'(status)
    : hit_elapsed ? {16'h0000, elapsed_q}
    : hit_pre ? {16'h0000, pre_q}
    : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= req;
      rdata_q <= req ? rmux : rdata_q;
    end
  end

  // The hours field survives a disable or a lockout; only reset restores the default.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hours_q <= CHG_HOURS_RST;
    else if (wr_ctrl)
      hours_q <= hours_clamped;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule

// >>> tb/cmsm_top_properties.sv
// Port-level checks for the charger mode state machine.
// Assumes DEB_CLK of at most 3, so eight steady samples outlast the sync, the filter and the output flop.
`timescale 1ns/1ps
module cmsm_top_properties
  import cmsm_pkg::*;
#(
  parameter int SEC_CLK = SEC_CYCLES,
  parameter int DEB_CLK = DEB_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cmsm_cmp_s cmp_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic charger_output_o,
  input wire logic fast_current_program_o,
  input wire logic battery_absent_flag_o,
  input wire logic charge_status_led_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic on_ok;
  assign on_ok = !cmp_i.input_undervoltage_lockout && !cmp_i.en_low;
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ldo_lit;
    (cmp_i.tsel_high && on_ok && cmp_i.ntc_above_90) [*8];
  endsequence
  sequence s_ldo_dark;
    (cmp_i.tsel_high && on_ok && !cmp_i.ntc_above_90) [*8];
  endsequence
  chk_ack_next: assert property (s_taken |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_lockout_hiz: assert property (cmp_i.input_undervoltage_lockout [*8] |-> ##2 !charge_status_led_oe_o)
    else $error("status pin driven in lockout");
  chk_enabled_drive: assert property (on_ok [*8] |-> ##2 charge_status_led_oe_o)
    else $error("status pin floating while enabled");
  chk_disable_off: assert property (cmp_i.en_low [*8] |-> ##2 !charger_output_o)
    else $error("output on while disabled");
  chk_fault_off: assert property ((cmp_i.input_overvoltage_fault || cmp_i.die_overtemperature) [*8]
    |-> ##2 !charger_output_o)
    else $error("output on during supply or die fault");
  chk_absent_flag: assert property ((cmp_i.ntc_above_95 && on_ok) [*8] |-> ##2 battery_absent_flag_o)
    else $error("absent flag low with pin at supply");
  chk_ldo_fast: assert property (s_ldo_lit |-> ##2 fast_current_program_o)
    else $error("regulator mode without fast limit");
  chk_ldo_needs_90: assert property (s_ldo_dark |-> ##2 !charger_output_o)
    else $error("regulator output on with pin below 90 percent");
  chk_pre_current: assert property ((cmp_i.vbat_below_precharge && !cmp_i.tsel_high) [*8]
    |-> ##2 !fast_current_program_o)
    else $error("fast limit with deep battery");
endmodule

// >>> tb/cmsm_pack_model.sv
// Behavioural supply, battery pack and thermistor divider as seen through the charger comparators.
// Assumes the bench changes its knobs just after a rising clock edge.
`timescale 1ns/1ps
module cmsm_pack_model
  import cmsm_pkg::*;
(
  input wire logic supply_i,
  input wire logic en_i,
  input wire logic over_volt_i,
  input wire logic hot_die_i,
  input wire logic load_i,
  input wire logic [1:0] ntc_i,
  input wire logic [1:0] tsel_i,
  input wire logic [1:0] vbat_i,
  output cmsm_cmp_s cmp_o
);
  // Thermistor: 0 in window, 1 hot, 2 cold, 3 pack removed so the pin rises to supply.
  // A grounded enable pin pulls every thermistor comparator low except the two clear comparators, which go high.
  // Timer pin: 0 resistor, 1 grounded, 2 at supply. Battery: 0 deep, 1 mid, 2 full.
  // The load knob stands for sensed current; tying it to the output would stop a timerless start.
  logic cold;
  logic hot;
  logic gone;
  assign cold = en_i && ntc_i[1];
  assign hot = en_i && ntc_i == 2'h1;
  assign gone = en_i && ntc_i == 2'h3;
  assign cmp_o = {!supply_i, over_volt_i, hot_die_i, !en_i, gone, gone, cold, !cold, hot, !hot,
                  tsel_i == 2'h2, tsel_i == 2'h1, vbat_i == 2'h0, vbat_i != 2'h2, load_i};
endmodule

// >>> tb/cmsm_top_tb.sv
// Self-checking bench for the charger mode state machine: pack model, Wishbone tasks, scenario list.
// Assumes shortened second and filter counts so the run stays near 19000 cycles.
`timescale 1ns/1ps
module cmsm_top_tb
  import cmsm_pkg::*;
;
  localparam int SEC_CLK = 20;
  localparam int DEB_CLK = 3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack, out, fast, absent, led, led_oe;
  cmsm_cmp_s cmp;
  logic supply = 1'b0;
  logic en = 1'b1;
  logic over_volt = 1'b0;
  logic hot_die = 1'b0;
  logic load = 1'b1;
  logic [1:0] ntc = 2'h0;
  logic [1:0] tsel = 2'h1;
  logic [1:0] vbat = 2'h1;
  logic [3:0] hw [3] = '{4'h0, 4'hF, 4'h1};
  logic [3:0] hx [3] = '{4'h1, 4'hA, 4'h1};
  logic [31:0] rd, e0;
  int n_mismatch = 0;
  int n_compared = 0;
  int k, c;

  cmsm_pack_model i_cmsm_pack_model (.supply_i(supply), .en_i(en), .over_volt_i(over_volt), .hot_die_i(hot_die),
    .load_i(load), .ntc_i(ntc), .tsel_i(tsel), .vbat_i(vbat), .cmp_o(cmp));
  cmsm_top #(.SEC_CLK(SEC_CLK), .DEB_CLK(DEB_CLK)) i_cmsm_top (.clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .charger_output_o(out),
    .fast_current_program_o(fast), .battery_absent_flag_o(absent), .charge_status_led_o(led),
    .charge_status_led_oe_o(led_oe));

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Called just after a rising edge; the request stands until ack is sampled high.
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= s;
    wb_adr <= a;
    wb_wdat <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    cmp_bit(wb_ack, 1'b1, "bus ack");
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_out(input logic exp, input int lim = 40);
    int n;
    n = 0;
    while (out !== exp && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    cmp_bit(out, exp, "output enable");
  endtask

  // Counts status pin changes over forty cycles: two blink periods at the shortened second.
  task automatic blinks();
    logic p;
    repeat (2) @(posedge clk_i);
    p = led;
    c = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      if (led !== p)
        c++;
      p = led;
    end
    cmp_word(32'(c), 32'h4, "blink changes");
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_io(1'b0, REG_CTRL, 32'h0);
    cmp_word(rd, 32'h4, "hours reset");
    for (k = 0; k < 3; k++)
    begin
      wb_io(1'b1, REG_CTRL, 32'(hw[k]));
      wb_io(1'b0, REG_CTRL, 32'h0);
      cmp_word(rd, 32'(hx[k]), "hours clamp");
    end
    wb_io(1'b1, REG_CTRL, 32'h7, 4'h0);
    wb_io(1'b0, REG_CTRL, 32'h0);
    cmp_word(rd, 32'h1, "ctrl write needs low lane");
    wb_io(1'b0, 8'h10, 32'h0);
    cmp_word(rd, 32'h0, "unmapped read");
    wb_io(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    wb_io(1'b0, REG_STATUS, 32'h0);
    cmp_word(rd & 32'hFFFF_FC07, 32'h0, "status read only");
    cmp_bit(led_oe, 1'b0, "pin floats in lockout");
    $display("test registers done");
    supply <= 1'b1;
    wait_out(1'b1);
    repeat (2) @(posedge clk_i);
    cmp_bit(led_oe, 1'b1, "pin driven");
    cmp_bit(led, 1'b0, "charging level");
    cmp_bit(fast, 1'b1, "fast limit");
    vbat <= 2'h2;
    load <= 1'b0;
    wait_out(1'b0);
    wb_io(1'b0, REG_STATUS, 32'h0);
    cmp_word(rd & 32'h7, 32'h4, "monitor state");
    cmp_bit(led, 1'b1, "complete level");
    load <= 1'b1;
    repeat (20) @(posedge clk_i);
    cmp_bit(led, 1'b1, "complete level held");
    vbat <= 2'h1;
    wait_out(1'b1);
    repeat (3) @(posedge clk_i);
    cmp_bit(led, 1'b0, "latch cleared on recharge");
    $display("test monitor done");
    for (k = 0; k < 2; k++)
    begin
      over_volt <= (k == 0);
      hot_die <= (k == 1);
      wait_out(1'b0);
      blinks();
      over_volt <= 1'b0;
      hot_die <= 1'b0;
      wait_out(1'b1);
    end
    $display("test faults done");
    ntc <= 2'h3;
    wait_out(1'b0);
    cmp_bit(absent, 1'b1, "absent flag");
    tsel <= 2'h2;
    wait_out(1'b1);
    cmp_bit(fast, 1'b1, "regulator limit");
    repeat (3) @(posedge clk_i);
    cmp_bit(led, 1'b0, "regulator status level");
    ntc <= 2'h0;
    wait_out(1'b0);
    cmp_bit(absent, 1'b0, "absent flag clear");
    repeat (10) @(posedge clk_i);
    cmp_bit(out, 1'b0, "regulator stays off below 90 percent");
    tsel <= 2'h0;
    wait_out(1'b1);
    $display("test regulator done");
    for (k = 0; k < 2; k++)
    begin
      repeat (60) @(posedge clk_i);
      ntc <= 2'(k + 1);
      wait_out(1'b0);
      blinks();
      wb_io(1'b0, REG_ELAPSED, 32'h0);
      e0 = rd;
      repeat (100) @(posedge clk_i);
      wb_io(1'b0, REG_ELAPSED, 32'h0);
      cmp_word(rd, e0, "timer frozen");
      ntc <= 2'h0;
      wait_out(1'b1);
      repeat (60) @(posedge clk_i);
      wb_io(1'b0, REG_ELAPSED, 32'h0);
      cmp_bit(rd > e0, 1'b1, "timer resumed");
    end
    $display("test temperature done");
    en <= 1'b0;
    wait_out(1'b0);
    repeat (2) @(posedge clk_i);
    cmp_bit(led_oe, 1'b0, "pin floats when disabled");
    vbat <= 2'h0;
    en <= 1'b1;
    wait_out(1'b1);
    cmp_bit(fast, 1'b0, "pre limit");
    repeat (17800) @(posedge clk_i);
    cmp_bit(out, 1'b1, "before quarter time");
    wait_out(1'b0, 400);
    wb_io(1'b0, REG_STATUS, 32'h0);
    cmp_word(rd & 32'h7, 32'h3, "pre fault state");
    vbat <= 2'h1;
    wait_out(1'b1);
    repeat (2) @(posedge clk_i);
    cmp_bit(fast, 1'b1, "fast after pre");
    $display("test pre fault done");
    supply <= 1'b0;
    wait_out(1'b0);
    repeat (2) @(posedge clk_i);
    cmp_bit(led_oe, 1'b0, "pin floats in lockout");
    $display("test lockout done");
    tally_and_finish();
  end

  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule

bind cmsm_top cmsm_top_properties #(.SEC_CLK(SEC_CLK), .DEB_CLK(DEB_CLK)) i_cmsm_top_properties (
  .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .charger_output_o(charger_output_o), .fast_current_program_o(fast_current_program_o),
  .battery_absent_flag_o(battery_absent_flag_o), .charge_status_led_oe_o(charge_status_led_oe_o));
